// File: logic/line_unit_alarm_loopback_regs.sv
// Purpose: host register bank for loopback, all-ones and alarm reporting
// Assumes: non-multiplexed parallel host port with active-low strobes
// Notes: host pins pass two flip-flops; write data is taken as the strobe ends
`timescale 1ns/1ps

// Function
// - id byte upper nibble returns fixed low nibble of the scan id code
// - id byte lower nibble returns the silicon revision field
// - analog loopback enable bit n turns on analog loopback of channel n
// - remote loopback enable bit n turns on remote loopback of channel n
// - all-ones enable bit n switches channel n all-ones generator on or off
// - signal absent status bit n reads one while channel n has no signal
// - driver fault status bit n is set when channel n driver is shorted
// - enabled change of a signal absent bit pulls interrupt output low
// - enabled change of a driver fault bit pulls interrupt output low
// - signal absent change flag n sets on any change and stays until cleared
// - driver fault change flag n sets on any change and stays until cleared
// - change flags record changes since last clear, not present status
// - any write to the soft reset register restores all defaults
// - registers 01h to 0ah other than status 04h and 05h hold 00h after power-up or any reset
module line_unit_alarm_loopback_regs #(
  parameter int CH = liu_regs_pkg::NUM_CH,
  parameter logic [3:0] ID_NIBBLE = 4'h5,  // arbitrary value
  parameter logic [3:0] REV_NIBBLE = 4'h1  // arbitrary value
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [liu_regs_pkg::ADDR_W-1:0] addr,
  input wire logic [liu_regs_pkg::DATA_W-1:0] data_in,
  output logic [liu_regs_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  output logic rdy_out,
  output logic rdy_oe,
  input wire logic [liu_regs_pkg::NUM_CH-1:0] signal_absent,
  input wire logic [liu_regs_pkg::NUM_CH-1:0] driver_fault_flag,
  output liu_regs_pkg::line_ctrl_s line_ctrl,
  output logic int_n
);
  import liu_regs_pkg::*;

  bank_s q;
  bank_s d;
  host_out_s hout;
  logic [NUM_CH-1:0] sa_level;
  logic [NUM_CH-1:0] sa_change;
  logic [NUM_CH-1:0] df_level;
  logic [NUM_CH-1:0] df_change;
  logic rd_act;
  logic wr_act;
  logic [DATA_W-1:0] sa_clr;
  logic [DATA_W-1:0] df_clr;
  logic write_done;

  if (CH != NUM_CH) begin : g_bad_ch
    $error("channel count must equal the register width of eight");
  end

  status_change_sync #(.CH(NUM_CH)) u_sa_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .raw(signal_absent),
    .level(sa_level),
    .change(sa_change)
  );

  status_change_sync #(.CH(NUM_CH)) u_df_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .raw(driver_fault_flag),
    .level(df_level),
    .change(df_change)
  );

  function automatic logic [DATA_W-1:0] read_mux(input logic [DEC_W-1:0] a,
                                                 input bank_s s,
                                                 input logic [NUM_CH-1:0] sa_lv,
                                                 input logic [NUM_CH-1:0] df_lv);
    logic [DATA_W-1:0] r;
    r = UNMAPPED_READ;
    case (a)
      OFF_DEVICE_VERSION_ID: begin
        r[ID_HI_MSB:ID_HI_LSB] = ID_NIBBLE;
        r[ID_LO_MSB:ID_LO_LSB] = REV_NIBBLE;
      end
      OFF_ANALOG_LOOPBACK_ENABLE: r = s.ctrl.analog_loopback_en;
      OFF_REMOTE_LOOPBACK_ENABLE: r = s.ctrl.remote_loopback_en;
      OFF_ALL_ONES_TX_ENABLE: r = s.ctrl.all_ones_tx_en;
      OFF_SIGNAL_ABSENT_STATUS: r = sa_lv;
      OFF_DRIVER_FAULT_STATUS: r = df_lv;
      OFF_SIGNAL_ABSENT_IRQ_MASK: r = s.signal_absent_irq_en;
      OFF_DRIVER_FAULT_IRQ_MASK: r = s.driver_fault_irq_en;
      OFF_SIGNAL_ABSENT_CHANGE_FLAGS: r = s.signal_absent_change;
      OFF_DRIVER_FAULT_CHANGE_FLAGS: r = s.driver_fault_change;
      OFF_SOFT_RESET_TRIGGER: r = REG_RESET;
      default: r = UNMAPPED_READ;
    endcase
    return r;
  endfunction

  // strobes are read only from the second synchroniser stage
  assign rd_act = q.hp2.cs & q.hp2.rd;
  assign wr_act = q.hp2.cs & q.hp2.wr;
  assign write_done = (q.acc == ACC_WRITE) && !wr_act;

  always_comb begin
    d = q;
    sa_clr = '0;
    df_clr = '0;
    d.hp1.cs = !cs_n;
    d.hp1.rd = !rd_n;
    d.hp1.wr = !wr_n;
    d.hp1.addr = addr;
    d.hp1.wdata = data_in;
    d.hp2 = q.hp1;
    case (q.acc)
      ACC_IDLE: begin
        if (rd_act) begin
          d.acc = ACC_READ;
          d.addr = q.hp2.addr[DEC_W-1:0];
          d.rdata = read_mux(q.hp2.addr[DEC_W-1:0], q, sa_level, df_level);
        end else if (wr_act) begin
          d.acc = ACC_WRITE;
          d.addr = q.hp2.addr[DEC_W-1:0];
          d.wdat = q.hp2.wdata;
        end
      end
      ACC_READ: begin
        if (rd_act) begin
          d.rdata = read_mux(q.addr, q, sa_level, df_level);
        end else begin
          d.acc = ACC_IDLE;
          // only bits the host actually saw are cleared
          if (q.addr == OFF_SIGNAL_ABSENT_CHANGE_FLAGS) begin
            sa_clr = q.rdata;
          end
          if (q.addr == OFF_DRIVER_FAULT_CHANGE_FLAGS) begin
            df_clr = q.rdata;
          end
        end
      end
      ACC_WRITE: begin
        if (wr_act) begin
          d.wdat = q.hp2.wdata;
        end else begin
          d.acc = ACC_IDLE;
          case (q.addr)
            OFF_ANALOG_LOOPBACK_ENABLE: d.ctrl.analog_loopback_en = q.wdat;
            OFF_REMOTE_LOOPBACK_ENABLE: d.ctrl.remote_loopback_en = q.wdat;
            OFF_ALL_ONES_TX_ENABLE: d.ctrl.all_ones_tx_en = q.wdat;
            OFF_SIGNAL_ABSENT_IRQ_MASK: d.signal_absent_irq_en = q.wdat;
            OFF_DRIVER_FAULT_IRQ_MASK: d.driver_fault_irq_en = q.wdat;
            OFF_SOFT_RESET_TRIGGER: begin
              // value written does not matter
              d.ctrl = '0;
              d.signal_absent_irq_en = REG_RESET;
              d.driver_fault_irq_en = REG_RESET;
              sa_clr = '1;
              df_clr = '1;
            end
            default: begin
            end
          endcase
        end
      end
      default: d.acc = ACC_IDLE;
    endcase
    // a change arriving with a clear still sets the flag
    d.signal_absent_change = (q.signal_absent_change & ~sa_clr) | sa_change;
    d.driver_fault_change = (q.driver_fault_change & ~df_clr) | df_change;
    d.rdy = (d.acc != ACC_IDLE);
    d.irq = |(d.signal_absent_change & d.signal_absent_irq_en)
          | |(d.driver_fault_change & d.driver_fault_irq_en);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  always_comb begin
    hout.rdata = q.rdata;
    hout.data_oe = (q.acc == ACC_READ);
    hout.rdy_out = q.rdy;
    hout.rdy_oe = q.hp2.cs;
  end

  assign data_out = hout.rdata;
  assign data_oe = hout.data_oe;
  assign rdy_out = hout.rdy_out;
  assign rdy_oe = hout.rdy_oe;
  assign line_ctrl = q.ctrl;
  assign int_n = !q.irq;

  id_read_value_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && q.acc == ACC_READ && rd_act && q.addr == OFF_DEVICE_VERSION_ID)
      |=> (q.rdata == {ID_NIBBLE, REV_NIBBLE}))
    else $error("identification byte read back wrong");

  alb_write_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && write_done && q.addr == OFF_ANALOG_LOOPBACK_ENABLE)
      |=> (line_ctrl.analog_loopback_en == $past(q.wdat)))
    else $error("analog loopback enable did not take written value");

  rlb_write_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && write_done && q.addr == OFF_REMOTE_LOOPBACK_ENABLE)
      |=> (line_ctrl.remote_loopback_en == $past(q.wdat)))
    else $error("remote loopback enable did not take written value");

  all_ones_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && !(write_done && (q.addr == OFF_ALL_ONES_TX_ENABLE
                            || q.addr == OFF_SOFT_RESET_TRIGGER)))
      |=> $stable(line_ctrl.all_ones_tx_en))
    else $error("all-ones enable changed without a write");

  absent_read_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && q.acc == ACC_READ && rd_act && q.addr == OFF_SIGNAL_ABSENT_STATUS)
      |=> (q.rdata == $past(sa_level)))
    else $error("signal absent status read does not match level");

  fault_read_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && q.acc == ACC_READ && rd_act && q.addr == OFF_DRIVER_FAULT_STATUS)
      |=> (q.rdata == $past(df_level)))
    else $error("driver fault status read does not match level");

  absent_int_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && |(sa_change & q.signal_absent_irq_en)) |=> !int_n)
    else $error("enabled signal absent change left interrupt high");

  fault_int_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && |(df_change & q.driver_fault_irq_en)) |=> !int_n)
    else $error("enabled driver fault change left interrupt high");

  absent_flag_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && |sa_change)
      |=> ((q.signal_absent_change & $past(sa_change)) == $past(sa_change)))
    else $error("signal absent change flag not set");

  fault_flag_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && |df_change)
      |=> ((q.driver_fault_change & $past(df_change)) == $past(df_change)))
    else $error("driver fault change flag not set");

  soft_reset_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && write_done && q.addr == OFF_SOFT_RESET_TRIGGER)
      |=> (line_ctrl == '0 && q.signal_absent_irq_en == REG_RESET
           && q.driver_fault_irq_en == REG_RESET))
    else $error("soft reset left a register set");

  reset_default_a: assert property (
    @(posedge mclk)
    rst |=> (line_ctrl == '0 && q.signal_absent_change == REG_RESET && int_n))
    else $error("registers not at default after reset");

  flag_read_clear_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && q.acc == ACC_READ && !rd_act && q.addr == OFF_SIGNAL_ABSENT_CHANGE_FLAGS
     && !(|sa_change))
      |=> ((q.signal_absent_change & $past(q.rdata)) == '0))
    else $error("read of change flags did not clear returned bits");

  fault_read_clear_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && q.acc == ACC_READ && !rd_act && q.addr == OFF_DRIVER_FAULT_CHANGE_FLAGS
     && !(|df_change))
      |=> ((q.driver_fault_change & $past(q.rdata)) == '0))
    else $error("read of fault change flags did not clear returned bits");

  int_release_a: assert property (
    @(posedge mclk) disable iff (rst)
    (!(|(q.signal_absent_change & q.signal_absent_irq_en))
     && !(|(q.driver_fault_change & q.driver_fault_irq_en)))
      |-> int_n)
    else $error("interrupt held low with no enabled flag set");

  absent_mask_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && write_done && q.addr == OFF_SIGNAL_ABSENT_IRQ_MASK)
      |=> (q.signal_absent_irq_en == $past(q.wdat)))
    else $error("signal absent interrupt enable did not take written value");

  fault_mask_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && write_done && q.addr == OFF_DRIVER_FAULT_IRQ_MASK)
      |=> (q.driver_fault_irq_en == $past(q.wdat)))
    else $error("driver fault interrupt enable did not take written value");

  all_ones_write_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && write_done && q.addr == OFF_ALL_ONES_TX_ENABLE)
      |=> (line_ctrl.all_ones_tx_en == $past(q.wdat)))
    else $error("all-ones enable did not take written value");

  absent_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && !(q.acc == ACC_READ && !rd_act) && !write_done)
      |=> ((q.signal_absent_change & $past(q.signal_absent_change))
           == $past(q.signal_absent_change)))
    else $error("signal absent change flag dropped without a clear");

  fault_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && !(q.acc == ACC_READ && !rd_act) && !write_done)
      |=> ((q.driver_fault_change & $past(q.driver_fault_change))
           == $past(q.driver_fault_change)))
    else $error("driver fault change flag dropped without a clear");

  soft_flags_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && write_done && q.addr == OFF_SOFT_RESET_TRIGGER)
      |=> (((q.signal_absent_change & ~$past(sa_change))
            | (q.driver_fault_change & ~$past(df_change))) == '0))
    else $error("soft reset left a change flag set");

  reset_mask_a: assert property (
    @(posedge mclk)
    rst |=> (q.signal_absent_irq_en == REG_RESET && q.driver_fault_irq_en == REG_RESET
             && q.driver_fault_change == REG_RESET))
    else $error("masks or flags not at default after reset");

endmodule // line_unit_alarm_loopback_regs

// File: logic/liu_regs_pkg.sv
// Purpose: shared constants and carriers for the line unit register bank
// Assumes: eight line channels, eight-bit host data, five decoded address bits
// Notes: host strobes are carried active high once they are inside the chip
package liu_regs_pkg;

  localparam int NUM_CH = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int DEC_W = 5;

  // register offsets, low five address bits only
  localparam logic [DEC_W-1:0] OFF_DEVICE_VERSION_ID = 5'h00;
  localparam logic [DEC_W-1:0] OFF_ANALOG_LOOPBACK_ENABLE = 5'h01;
  localparam logic [DEC_W-1:0] OFF_REMOTE_LOOPBACK_ENABLE = 5'h02;
  localparam logic [DEC_W-1:0] OFF_ALL_ONES_TX_ENABLE = 5'h03;
  localparam logic [DEC_W-1:0] OFF_SIGNAL_ABSENT_STATUS = 5'h04;
  localparam logic [DEC_W-1:0] OFF_DRIVER_FAULT_STATUS = 5'h05;
  localparam logic [DEC_W-1:0] OFF_SIGNAL_ABSENT_IRQ_MASK = 5'h06;
  localparam logic [DEC_W-1:0] OFF_DRIVER_FAULT_IRQ_MASK = 5'h07;
  localparam logic [DEC_W-1:0] OFF_SIGNAL_ABSENT_CHANGE_FLAGS = 5'h08;
  localparam logic [DEC_W-1:0] OFF_DRIVER_FAULT_CHANGE_FLAGS = 5'h09;
  localparam logic [DEC_W-1:0] OFF_SOFT_RESET_TRIGGER = 5'h0a;

  // identification byte fields
  localparam int ID_HI_MSB = 7;
  localparam int ID_HI_LSB = 4;
  localparam int ID_LO_MSB = 3;
  localparam int ID_LO_LSB = 0;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_WRITE} acc_e;

  // host port pins as seen inside, strobes active high
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } host_in_s;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic data_oe;
    logic rdy_out;
    logic rdy_oe;
  } host_out_s;

  typedef struct packed {
    logic [NUM_CH-1:0] analog_loopback_en;
    logic [NUM_CH-1:0] remote_loopback_en;
    logic [NUM_CH-1:0] all_ones_tx_en;
  } line_ctrl_s;

  typedef struct packed {
    host_in_s hp1;
    host_in_s hp2;
    acc_e acc;
    logic [DEC_W-1:0] addr;
    logic [DATA_W-1:0] wdat;
    logic [DATA_W-1:0] rdata;
    line_ctrl_s ctrl;
    logic [NUM_CH-1:0] signal_absent_irq_en;
    logic [NUM_CH-1:0] driver_fault_irq_en;
    logic [NUM_CH-1:0] signal_absent_change;
    logic [NUM_CH-1:0] driver_fault_change;
    logic rdy;
    logic irq;
  } bank_s;

endpackage

// File: logic/status_change_sync.sv
// Purpose: bring line status levels onto mclk and flag every change
// Assumes: status inputs are asynchronous levels from the line side
// Notes: change pulses last one enabled cycle
`timescale 1ns/1ps
module status_change_sync #(
  parameter int CH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [CH-1:0] raw,
  output logic [CH-1:0] level,
  output logic [CH-1:0] change
);
  import liu_regs_pkg::*;

  typedef struct packed {
    logic [CH-1:0] s1;
    logic [CH-1:0] s2;
    logic [CH-1:0] prev;
  } sync_s;

  sync_s q;
  sync_s d;

  if (CH < 1 || CH > DATA_W) begin : g_bad_ch
    $error("channel count must lie between one and the data width");
  end

  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    d.prev = q.s2;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign level = q.s2;

  for (genvar i = 0; i < CH; i++) begin : g_chg
    // either edge of a synchronised bit against its previous value
    assign change[i] = q.s2[i] ^ q.prev[i];
  end

endmodule // status_change_sync

// File: tb/host_port_model.sv
// Purpose: host processor on the non-multiplexed parallel port of the register bank
// Assumes: strobes held until ready is seen, released lines show inverted data
// Notes: access reports ok low when ready never comes or never drops
`timescale 1ns/1ps
module host_port_model (
  input wire logic mclk,
  input wire logic [liu_regs_pkg::DATA_W-1:0] data_out,
  input wire logic rdy_out,
  input wire logic data_oe,
  input wire logic rdy_oe,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [liu_regs_pkg::ADDR_W-1:0] addr,
  output logic [liu_regs_pkg::DATA_W-1:0] data_in
);
  import liu_regs_pkg::*;

  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 8'h00;
    data_in = 8'h00;
  end

  task automatic access(input logic wr, input logic [DEC_W-1:0] off,
                        input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata,
                        output logic ok, output logic [1:0] oe);
    int n;
    ok = 1'b0;
    oe = 2'b00;
    rdata = 8'h00;
    @(posedge mclk);
    #2;
    cs_n = 1'b0;
    rd_n = wr;
    wr_n = ~wr;
    addr = {3'h0, off};
    data_in = wdata;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge mclk);
      if (rdy_out === 1'b1) begin
        ok = 1'b1;
        rdata = data_out;
        oe = {data_oe, rdy_oe};
      end
    end
    #2;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    // address and data stay until the device has seen the release
    for (n = 0; n < 20 && rdy_out !== 1'b0; n++) begin
      @(posedge mclk);
    end
    if (rdy_out !== 1'b0) begin
      ok = 1'b0;
    end
    repeat (3) @(posedge mclk);
    #2;
    data_in = ~wdata;
  endtask
endmodule  // host_port_model

// File: tb/line_unit_alarm_loopback_regs_tb.sv
// Purpose: self-checking bench for the line unit register bank
// Assumes: host model drives the port; bench drives line status levels
// Notes: status edges take three cycles to reach flags and interrupt
`timescale 1ns/1ps
module line_unit_alarm_loopback_regs_tb;
  import liu_regs_pkg::*;
  localparam logic [3:0] ID_HI = 4'ha;  // arbitrary value
  localparam logic [3:0] ID_LO = 4'h6;  // arbitrary value
  logic mclk;
  logic rst;
  logic ce;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_in;
  logic [DATA_W-1:0] data_out;
  logic data_oe;
  logic rdy_out;
  logic rdy_oe;
  logic [NUM_CH-1:0] signal_absent;
  logic [NUM_CH-1:0] driver_fault_flag;
  line_ctrl_s line_ctrl;
  logic int_n;
  int errors;
  int tests_run;

  line_unit_alarm_loopback_regs #(.ID_NIBBLE(ID_HI), .REV_NIBBLE(ID_LO)) dut (
    .mclk(mclk), .rst(rst), .ce(ce), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .rdy_out(rdy_out), .rdy_oe(rdy_oe), .signal_absent(signal_absent),
    .driver_fault_flag(driver_fault_flag), .line_ctrl(line_ctrl), .int_n(int_n)
  );

  host_port_model host (
    .mclk(mclk), .data_out(data_out), .rdy_out(rdy_out), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
    .data_oe(data_oe), .rdy_oe(rdy_oe)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic results();
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [4:0] off, input logic [7:0] d,
                      output logic [7:0] q);
    logic ok;
    logic [1:0] oe;
    host.access(w, off, d, q, ok, oe);
    if (!ok) begin
      errors++;
      results();
    end
    chk("data_oe rdy_oe busy", {22'h0, ~w, 1'b1}, {22'h0, oe});
    chk("data_oe rdy_oe idle", 24'h0, {22'h0, data_oe, rdy_oe});
  endtask

  task automatic wr(input logic [4:0] off, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, off, d, q);
  endtask

  task automatic rdc(input logic [4:0] off, input logic [7:0] exp);
    logic [7:0] q;
    xfer(1'b0, off, 8'h00, q);
    chk($sformatf("reg %h", off), {16'h0, exp}, {16'h0, q});
  endtask

  task automatic set_line(input logic sel, input logic [7:0] v);
    @(posedge mclk);
    #2;
    if (sel) driver_fault_flag = v;
    else signal_absent = v;
    repeat (4) @(posedge mclk);
    #2;
  endtask

  task automatic t_reset();
    rdc(5'h00, {ID_HI, ID_LO});
    for (int i = 1; i <= 10; i++) rdc(5'(i), 8'h00);
    chk("line_ctrl", 24'h0, line_ctrl);
    chk("int_n", 24'h1, {23'h0, int_n});
  endtask

  task automatic t_rw();
    wr(5'h01, 8'ha5);
    wr(5'h02, 8'h3c);
    wr(5'h03, 8'h81);
    wr(5'h06, 8'h5a);
    wr(5'h07, 8'hc3);
    chk("line_ctrl", 24'ha53c81, line_ctrl);
    rdc(5'h06, 8'h5a);
    rdc(5'h07, 8'hc3);
    wr(5'h03, 8'h00);
    chk("all_ones", 24'h0, {16'h0, line_ctrl.all_ones_tx_en});
    wr(5'h00, 8'hff);
    wr(5'h04, 8'hff);
    wr(5'h08, 8'hff);
    rdc(5'h00, {ID_HI, ID_LO});
    rdc(5'h04, 8'h00);
    rdc(5'h08, 8'h00);
    rdc(5'h0b, 8'h00);
    rdc(5'h01, 8'ha5);
  endtask

  task automatic t_alarm(input logic sel);
    logic [4:0] st;
    st = sel ? 5'h05 : 5'h04;
    wr(st + 5'h02, 8'h01);
    set_line(sel, 8'h81);
    chk("int_n", 24'h0, {23'h0, int_n});
    rdc(st, 8'h81);
    set_line(sel, 8'h00);
    rdc(st, 8'h00);
    chk("int_n", 24'h0, {23'h0, int_n});
    rdc(st + 5'h04, 8'h81);
    chk("int_n", 24'h1, {23'h0, int_n});
    rdc(st + 5'h04, 8'h00);
    set_line(sel, 8'h80);
    chk("int_n", 24'h1, {23'h0, int_n});
    rdc(st + 5'h04, 8'h80);
    set_line(sel, 8'h00);
    rdc(st + 5'h04, 8'h80);
  endtask

  task automatic t_soft();
    wr(5'h01, 8'hff);
    wr(5'h06, 8'hff);
    set_line(1'b0, 8'h10);
    chk("int_n", 24'h0, {23'h0, int_n});
    wr(5'h0a, 8'h5e);
    chk("line_ctrl", 24'h0, line_ctrl);
    chk("int_n", 24'h1, {23'h0, int_n});
    for (int i = 1; i <= 10; i++) begin
      if (i != 4) rdc(5'(i), 8'h00);
    end
    rdc(5'h04, 8'h10);
  endtask

  task automatic t_freeze();
    wr(5'h06, 8'hff);
    @(posedge mclk);
    #2;
    ce = 1'b0;
    set_line(1'b0, 8'h00);
    chk("int_n frozen", 24'h1, {23'h0, int_n});
    @(posedge mclk);
    #2;
    ce = 1'b1;
    repeat (4) @(posedge mclk);
    #2;
    chk("int_n", 24'h0, {23'h0, int_n});
    rdc(5'h08, 8'h10);
  endtask

  initial begin
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    ce = 1'b1;
    signal_absent = 8'h00;
    driver_fault_flag = 8'h00;
    repeat (16) @(posedge mclk);
    #2;
    rst = 1'b0;
    t_reset();
    t_rw();
    t_alarm(1'b0);
    t_alarm(1'b1);
    t_soft();
    t_freeze();
    results();
  end
endmodule  // line_unit_alarm_loopback_regs_tb
